/* File: design/ocd_bank.sv */
// configuration register bank for one output clock channel
//
// Summary of operation
// - skew bits 5:0 set coarse delay, 0 to 63 oscillator periods.
// - skew bits 7:6 add fine delay of 0 to 3 steps of 30 ps.
// - driver-select bit 4 extends fine code to three bits, 0 to 7 steps.
// - driver-select bits 4:3 give supply: 00 1.8 V, 01 2.5 V, 10 3.3 V.
// - driver-select bits 2:0 choose differential driver standard.
// - termination nibble 0000 external, 0010 pull-up, 0001 pull-down.
// - termination nibble 0100 positive only, 1000 negative only, 1100 both CMOS.
// - upper divider low nibble gives ratio bits 19:16.
// - middle divider byte gives ratio bits 15:8.
// - lower divider byte gives ratio bits 7:0, twenty bits total.
// - phase bits 7:6 pick leg phases; 00 is true to positive, complement to negative.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_defs.svh"
module ocd_bank (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // delay
  output logic [5:0] o_output_skew_coarse,
  output logic [2:0] o_output_skew_fine,
  // driver
  output ocd_pkg::ocd_supply_t o_output_supply_level,
  output ocd_pkg::ocd_std_t o_driver_standard_code,
  output logic o_term_pullup,
  output logic o_term_pulldown,
  output logic o_single_ended,
  output logic o_positive_output_pin_cmos,
  output logic o_negative_output_pin_cmos,
  output ocd_pkg::ocd_phase_t o_positive_driver_leg,
  output ocd_pkg::ocd_phase_t o_negative_driver_leg,
  output logic [2:0] o_se_drive_strength,
  // divider
  output logic [19:0] o_output_divide_ratio,
  output logic o_ratio_update
);
  import ocd_pkg::*;

  typedef struct packed {
    logic [7:0] skew;
    logic [4:0] drv;
    logic [3:0] term;
    logic [3:0] div_up;
    logic [7:0] div_mid;
    logic [7:0] div_lo;
    logic [1:0] phase;
    logic [2:0] strength;
    logic [7:0] rdata;
    logic rd_valid;
    logic commit;
  } ocd_bank_state_t;

  ocd_bank_state_t st_r;
  ocd_bank_state_t st_nxt;

  ocd_ratio_if ratio_if ();

  // readback image of one address; unmapped and reserved bits read zero
  function automatic logic [7:0] read_image(input ocd_bank_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OCD_ADDR_SKEW: v = s.skew;
      `OCD_ADDR_DRV: v = {3'h0, s.drv};
      `OCD_ADDR_TERM: v = {4'h0, s.term};
      `OCD_ADDR_DIV_UP: v = {4'h0, s.div_up};
      `OCD_ADDR_DIV_MID: v = s.div_mid;
      `OCD_ADDR_DIV_LO: v = s.div_lo;
      `OCD_ADDR_PHASE: v = {s.phase, 3'h0, s.strength};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = i_reg_rd_en;
    st_nxt.commit = 1'b0;
    // read sees the value before a same-cycle write; reads change nothing
    if (i_reg_rd_en) begin
      st_nxt.rdata = read_image(st_r, i_reg_addr);
    end
    if (i_reg_wr_en) begin
      case (i_reg_addr)
        `OCD_ADDR_SKEW: st_nxt.skew = i_reg_wdata;
        `OCD_ADDR_DRV: st_nxt.drv = i_reg_wdata[4:0];
        `OCD_ADDR_TERM: st_nxt.term = i_reg_wdata[`OCD_TERM_MSB:0];
        `OCD_ADDR_DIV_UP: st_nxt.div_up = i_reg_wdata[`OCD_DIV_UP_MSB:0];
        `OCD_ADDR_DIV_MID: st_nxt.div_mid = i_reg_wdata;
        `OCD_ADDR_DIV_LO: begin
          // lower byte written last arms the commit, so upper bytes may be staged first
          st_nxt.div_lo = i_reg_wdata;
          st_nxt.commit = 1'b1;
        end
        `OCD_ADDR_PHASE: begin
          st_nxt.phase = i_reg_wdata[`OCD_PHASE_MSB:`OCD_PHASE_LSB];
          st_nxt.strength = i_reg_wdata[`OCD_STRENGTH_MSB:0];
        end
        default: st_nxt.commit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ratio_if.staged = {st_r.div_up, st_r.div_mid, st_r.div_lo};
  assign ratio_if.commit = st_r.commit;

  ocd_ratio_commit u_commit (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .ratio_if(ratio_if.apply)
  );

  assign o_reg_rdata = st_r.rdata;
  assign o_reg_rd_valid = st_r.rd_valid;
  assign o_output_skew_coarse = st_r.skew[`OCD_SKEW_COARSE_MSB:0];
  // bit 4 doubles as supply msb and fine-delay extension; both uses are honoured
  assign o_output_skew_fine = {st_r.drv[`OCD_DRV_FINE_EXT_BIT],
                               st_r.skew[`OCD_SKEW_FINE_MSB:`OCD_SKEW_FINE_LSB]};
  assign o_output_supply_level = ocd_supply_t'(st_r.drv[`OCD_DRV_SUPPLY_MSB:`OCD_DRV_SUPPLY_LSB]);
  assign o_driver_standard_code = ocd_std_t'(st_r.drv[`OCD_DRV_STD_MSB:0]);
  assign o_term_pullup = (st_r.term == 4'h2);
  assign o_term_pulldown = (st_r.term == 4'h1);
  assign o_positive_output_pin_cmos = (st_r.term == 4'h4) || (st_r.term == 4'hc);
  assign o_negative_output_pin_cmos = (st_r.term == 4'h8) || (st_r.term == 4'hc);
  assign o_single_ended = o_positive_output_pin_cmos || o_negative_output_pin_cmos;
  assign o_positive_driver_leg = ocd_phase_t'(st_r.phase[1]);
  // negative leg takes the complement clock whenever the low phase bit is clear
  assign o_negative_driver_leg = ocd_phase_t'(~st_r.phase[0]);
  assign o_se_drive_strength = st_r.strength;
  assign o_output_divide_ratio = ratio_if.applied;
  assign o_ratio_update = ratio_if.update;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_coarse;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_SKEW |=> o_output_skew_coarse == $past(i_reg_wdata[5:0]);
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse delay does not follow skew write");

  property p_fine;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_SKEW |=> o_output_skew_fine[1:0] == $past(i_reg_wdata[7:6]);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine delay does not follow skew bits 7:6");

  property p_fine_ext;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_DRV |=> o_output_skew_fine[2] == $past(i_reg_wdata[4]);
  endproperty
  a_fine_ext: assert property (p_fine_ext)
    else $error("fine delay extension bit wrong");

  property p_supply;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_DRV |=> o_output_supply_level == $past(i_reg_wdata[4:3]);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply level wrong after write");

  property p_standard;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_DRV |=> o_driver_standard_code == $past(i_reg_wdata[2:0]);
  endproperty
  a_standard: assert property (p_standard)
    else $error("driver standard wrong after write");

  property p_pullup;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_TERM && i_reg_wdata[3:0] == 4'h2
      |=> o_term_pullup && !o_term_pulldown && !o_single_ended;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pattern 0010 did not select pull-up");

  property p_both_cmos;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_TERM && i_reg_wdata[3:0] == 4'hc
      |=> o_positive_output_pin_cmos && o_negative_output_pin_cmos && !o_term_pullup;
  endproperty
  a_both_cmos: assert property (p_both_cmos)
    else $error("pattern 1100 did not drive both pins");

  property p_phase_default;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_PHASE && i_reg_wdata[7:6] == 2'b00
      |=> o_positive_driver_leg == OCD_PH_TRUE && o_negative_driver_leg == OCD_PH_COMP;
  endproperty
  a_phase_default: assert property (p_phase_default)
    else $error("phase code 00 misrouted");

  property p_readback;
    i_reg_rd_en && i_reg_addr == `OCD_ADDR_SKEW
      |=> o_reg_rd_valid && o_reg_rdata == {$past(o_output_skew_fine[1:0]), $past(o_output_skew_coarse)};
  endproperty
  a_readback: assert property (p_readback)
    else $error("skew readback does not match stored value");

  property p_commit_delay;
    i_reg_wr_en && i_reg_addr == `OCD_ADDR_DIV_LO |=> ##1 o_ratio_update && o_output_divide_ratio[7:0] == $past(i_reg_wdata, 2);
  endproperty
  a_commit_delay: assert property (p_commit_delay)
    else $error("lower byte write did not commit ratio two cycles later");

endmodule
`default_nettype wire

/* File: design/ocd_defs.svh */
// offsets, field positions and reset values of the output divider configuration bank
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH

`define OCD_ADDR_SKEW 8'h3c
`define OCD_ADDR_DRV 8'h3d
`define OCD_ADDR_TERM 8'h3f
`define OCD_ADDR_DIV_UP 8'h40
`define OCD_ADDR_DIV_MID 8'h41
`define OCD_ADDR_DIV_LO 8'h42
`define OCD_ADDR_PHASE 8'h43

`define OCD_SKEW_COARSE_MSB 5
`define OCD_SKEW_FINE_MSB 7
`define OCD_SKEW_FINE_LSB 6
`define OCD_DRV_FINE_EXT_BIT 4
`define OCD_DRV_SUPPLY_MSB 4
`define OCD_DRV_SUPPLY_LSB 3
`define OCD_DRV_STD_MSB 2
`define OCD_TERM_MSB 3
`define OCD_DIV_UP_MSB 3
`define OCD_PHASE_MSB 7
`define OCD_PHASE_LSB 6
`define OCD_STRENGTH_MSB 2

`define OCD_FINE_STEP_PS 30

`define OCD_RST_BYTE 8'h00
`define OCD_RST_RATIO 20'h00000

`endif

/* File: design/ocd_pkg.sv */
// types shared by the output divider configuration bank
package ocd_pkg;

  typedef enum logic [1:0] {
    OCD_VDD_1V8 = 2'b00,
    OCD_VDD_2V5 = 2'b01,
    OCD_VDD_3V3 = 2'b10,
    OCD_VDD_RSVD = 2'b11
  } ocd_supply_t;

  typedef enum logic [2:0] {
    OCD_STD_LVDS = 3'b000,
    OCD_STD_LVPECL_CM = 3'b001,
    OCD_STD_CML = 3'b010,
    OCD_STD_HCSL = 3'b011,
    OCD_STD_LVDS_BOOST = 3'b100,
    OCD_STD_LVPECL_NOCM = 3'b101,
    OCD_STD_RSVD6 = 3'b110,
    OCD_STD_RSVD7 = 3'b111
  } ocd_std_t;

  // per-leg phase source: true or complement clock
  typedef enum logic {
    OCD_PH_TRUE = 1'b0,
    OCD_PH_COMP = 1'b1
  } ocd_phase_t;

endpackage

/* File: design/ocd_ratio_if.sv */
// carries the staged divide ratio from the register bank to the commit stage
`timescale 1ns/100ps
`default_nettype none
interface ocd_ratio_if;
  logic [19:0] staged;
  logic commit;
  logic [19:0] applied;
  logic update;
  modport regs (output staged, output commit, input applied, input update);
  modport apply (input staged, input commit, output applied, output update);
endinterface
`default_nettype wire

/* File: design/ocd_ratio_commit.sv */
// applies the twenty-bit divide ratio as one consistent word
`timescale 1ns/100ps
`default_nettype none
`include "ocd_defs.svh"
module ocd_ratio_commit (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // staged ratio and applied ratio
  ocd_ratio_if.apply ratio_if
);
  import ocd_pkg::*;

  typedef struct packed {
    logic [19:0] ratio;
    logic update;
  } ocd_commit_state_t;

  ocd_commit_state_t st_r;
  ocd_commit_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.update = 1'b0;
    if (ratio_if.commit) begin
      st_nxt.ratio = ratio_if.staged;
      st_nxt.update = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '{ratio: `OCD_RST_RATIO, update: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ratio_if.applied = st_r.ratio;
  assign ratio_if.update = st_r.update;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_ratio_hold;
    !ratio_if.commit |=> $stable(ratio_if.applied);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold)
    else $error("divide ratio changed without a commit");

  property p_ratio_upper;
    ratio_if.commit |=> ratio_if.applied[19:16] == $past(ratio_if.staged[19:16]);
  endproperty
  a_ratio_upper: assert property (p_ratio_upper)
    else $error("ratio bits 19:16 not taken from upper byte");

  property p_ratio_middle;
    ratio_if.commit |=> ratio_if.applied[15:8] == $past(ratio_if.staged[15:8]);
  endproperty
  a_ratio_middle: assert property (p_ratio_middle)
    else $error("ratio bits 15:8 not taken from middle byte");

  property p_ratio_lower;
    ratio_if.commit |=> ratio_if.applied[7:0] == $past(ratio_if.staged[7:0]) && ratio_if.update;
  endproperty
  a_ratio_lower: assert property (p_ratio_lower)
    else $error("ratio bits 7:0 not taken from lower byte");

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the output divider configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr_en = 1'b0;
  logic i_reg_rd_en = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid, pu, pd, se, pcm, ncm, upd;
  logic [5:0] coarse;
  logic [2:0] fine, strg;
  ocd_pkg::ocd_supply_t supply;
  ocd_pkg::ocd_std_t drv_std;
  ocd_pkg::ocd_phase_t pleg, nleg;
  logic [19:0] ratio, exp_ratio;
  logic [7:0] m [8'h3c:8'h43];
  int n_fail = 0;
  int n_checks = 0;
  int tp [6] = '{0, 2, 1, 4, 8, 12};

  always #12.5 i_core_clk = ~i_core_clk;

  ocd_bank i_ocd_bank (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_reg_addr(i_reg_addr), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .o_reg_rd_valid(rvalid),
    .o_output_skew_coarse(coarse), .o_output_skew_fine(fine),
    .o_output_supply_level(supply), .o_driver_standard_code(drv_std),
    .o_term_pullup(pu), .o_term_pulldown(pd), .o_single_ended(se),
    .o_positive_output_pin_cmos(pcm), .o_negative_output_pin_cmos(ncm),
    .o_positive_driver_leg(pleg), .o_negative_driver_leg(nleg),
    .o_se_drive_strength(strg), .o_output_divide_ratio(ratio), .o_ratio_update(upd));

  // undefined bits are dropped, so the model keeps only the writable ones
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h3c, 8'h41, 8'h42: return 8'hff;
      8'h3d: return 8'h1f;
      8'h3f, 8'h40: return 8'h0f;
      8'h43: return 8'hc7;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return (a >= 8'h3c && a <= 8'h43) ? m[a] : 8'h00;
  endfunction

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_outs;
    logic [3:0] t;
    logic [1:0] p;
    t = m[8'h3f][3:0];
    p = m[8'h43][7:6];
    chk("coarse", coarse, m[8'h3c][5:0]);
    chk("fine", fine, {m[8'h3d][4], m[8'h3c][7:6]});
    chk("supply", supply, m[8'h3d][4:3]);
    chk("standard", drv_std, m[8'h3d][2:0]);
    chk("pullup", pu, t == 4'h2);
    chk("pulldown", pd, t == 4'h1);
    chk("pos_cmos", pcm, t == 4'h4 || t == 4'hc);
    chk("neg_cmos", ncm, t == 4'h8 || t == 4'hc);
    chk("single", se, t == 4'h4 || t == 4'h8 || t == 4'hc);
    chk("pos_leg", pleg, p[1]);
    chk("neg_leg", nleg, p == 2'b00 || p == 2'b10);
    chk("strength", strg, m[8'h43][2:0]);
    chk("ratio", ratio, exp_ratio);
  endtask

  task automatic idle;
    i_reg_wr_en = 1'b0;
    i_reg_rd_en = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr_en = 1'b1;
    @(negedge i_core_clk);
    if (a >= 8'h3c && a <= 8'h43) begin
      m[a] = d & wmask(a);
    end
  endtask

  // a lower-byte write commits the staged word one cycle after the field update
  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    idle();
    if (a == 8'h42) begin
      chk("ratio_hold", ratio, exp_ratio);
      @(negedge i_core_clk);
      exp_ratio = {m[8'h40][3:0], m[8'h41], m[8'h42]};
      chk("ratio_new", ratio, exp_ratio);
      chk("update", upd, 1'b1);
    end
    chk_outs();
    // a quiet cycle before the next request, so no strobe is set twice in one step
    @(negedge i_core_clk);
    chk("upd_low", upd, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    i_reg_addr = a;
    i_reg_rd_en = 1'b1;
    @(negedge i_core_clk);
    idle();
    chk("rd_valid", rvalid, 1'b1);
    chk("rdata", rdata, exp_rd(a));
    @(negedge i_core_clk);
    chk("rd_drop", rvalid, 1'b0);
    chk("rd_hold", rdata, exp_rd(a));
  endtask

  initial begin
    #(25 * 4000);
    n_fail++;
    stop_test();
  end

  initial begin
    logic [7:0] a;
    void'($urandom(42404));
    foreach (m[i]) m[i] = 8'h00;
    exp_ratio = 20'h00000;
    repeat (20) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    chk_outs();
    for (int i = 8'h3b; i <= 8'h44; i++) rd(8'(i));
    @(negedge i_core_clk);
    chk("rd_pulse", rvalid, 1'b0);
    for (int i = 0; i < 8; i++) begin
      do_wr(8'h3d, {3'($urandom), 2'(i % 3), 3'(i)});
      rd(8'h3d);
    end
    foreach (tp[i]) begin
      do_wr(8'h3f, {4'($urandom), 4'(tp[i])});
      rd(8'h3f);
    end
    for (int i = 0; i < 4; i++) begin
      do_wr(8'h43, {2'(i), 6'($urandom)});
    end
    do_wr(8'h3c, 8'h3f);
    do_wr(8'h3c, 8'hc0);
    // staged bytes back to back, then the committing byte
    wr(8'h40, 8'hfa);
    wr(8'h41, 8'h5c);
    do_wr(8'h42, 8'h3e);
    chk("ratio_full", ratio, 20'ha5c3e);
    i_reg_addr = 8'h3c;
    i_reg_wdata = 8'h81;
    i_reg_wr_en = 1'b1;
    i_reg_rd_en = 1'b1;
    @(negedge i_core_clk);
    idle();
    chk("rd_old", rdata, m[8'h3c]);
    chk("rd_old_valid", rvalid, 1'b1);
    m[8'h3c] = 8'h81;
    chk_outs();
    @(negedge i_core_clk);
    repeat (40) begin
      a = 8'h3b + 8'($urandom % 10);
      do_wr(a, 8'($urandom));
      rd(a);
    end
    // reset in mid-run must clear every field, staged divider bytes included
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    foreach (m[i]) m[i] = 8'h00;
    exp_ratio = 20'h00000;
    chk_outs();
    chk("rst_valid", rvalid, 1'b0);
    i_reset_n = 1'b1;
    for (int i = 8'h3c; i <= 8'h43; i++) rd(8'(i));
    do_wr(8'h42, 8'h07);
    chk("ratio_after_rst", ratio, 20'h00007);
    stop_test();
  end
endmodule
`default_nettype wire
